// File: hw/sld_fifo.sv
// Frame FIFO with a registered read word
`timescale 1ns/1ps
module sld_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Streams
  sld_stream_if.sink   wr,
  sld_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic [WIDTH-1:0]            out_data;
    logic                        out_valid;
  } sld_fifo_state_type;

  sld_fifo_state_type s;
  sld_fifo_state_type next_s;
  logic               push;
  logic               take;
  logic               pop;

  // Depth must be a power of two: pointers wrap by overflow
  always_comb begin
    next_s = s;
    push   = wr.valid && (s.cnt < (AW+1)'(DEPTH));
    pop    = rd.ready && s.out_valid;
    take   = (!s.out_valid || pop) && (s.cnt != '0);
    if (pop) begin
      next_s.out_valid = 1'b0;
    end
    if (take) begin
      next_s.out_data  = s.mem[s.rp];
      next_s.out_valid = 1'b1;
      next_s.rp        = s.rp + 1'b1;
    end
    if (push) begin
      next_s.mem[s.wp] = wr.data;
      next_s.wp        = s.wp + 1'b1;
    end
    next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, take};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wr.ready = (s.cnt < (AW+1)'(DEPTH));
  assign rd.valid = s.out_valid;
  assign rd.data  = s.out_data;

  // ==========================================================
  // Checks
  a_fifo_bounded: assert property (@(posedge clk) disable iff (rst)
    s.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
  a_fifo_refill: assert property (@(posedge clk) disable iff (rst)
    (pop && s.cnt != '0) |=> rd.valid && rd.data == $past(s.mem[s.rp]))
    else $error("fifo head not refilled in order");
  c_fifo_full: cover property (@(posedge clk) disable iff (rst) !wr.ready);

endmodule // sld_fifo

// File: hw/sld_pkg.sv
// Constants shared by the serial display latch design
// What this block does
// [RL1] Frames travel on just two signals, a serial clock and a serial data line, with no load strobe.
// [RL2] The host opens every frame with a start bit of one and follows it with exactly 35 data bits.
// [RL3] The 35 data bits are copied to the output latches only after the 36th bit, start bit included, is in.
// [RL4] The latch transfer is made on the high phase of the serial clock that carries the 36th bit.
// [RL5] After the transfer the whole shift chain is cleared, ready for the next frame.
// [RL6] The first stage is never lost to the clear, so frames may follow back to back.
// [RL7] The host always sends a full 36 clocks; a short burst leaves the chain uncleared and unlatched.
// [RL8] Reset clears every shift stage and every output latch.
// [RL9] After reset, reception resumes with a start bit seen on the first clock; the link here sees one only from the third clock.
// [RL10] The first data bit after the start bit goes to output 1, later bits to the following outputs.
// [RL11] A latched one turns its output on; a latched zero leaves it off.
// [RL12] Outputs are static, driven from the latches, and change only when a new frame differs.
// [RL13] On the enable variant the active-low input enable replaces the 35th output, leaving 34.
// [RL14] The host keeps the serial clock at or below 0.5 MHz; the bench host here clocks it with a 32 ns period.
// [RL15] Data is presented before, and sampled on, the rising edge of the serial clock.
// [RL16] While the input enable is inactive, clock and data are ignored: nothing shifts or latches.
package sld_pkg;

  // ==========================================================
  // Frame format
  localparam int        DATA_BITS  = 35;
  localparam int        FRAME_BITS = 36;
  localparam int        CNT_W      = 6;
  localparam logic [5:0] CNT_IDLE  = 6'h00;
  localparam logic [5:0] CNT_FIRST = 6'h01;
  localparam logic [5:0] CNT_LAST  = 6'h23;

  // ==========================================================
  // Buffering and reset values
  localparam int         FIFO_DEPTH = 8;
  localparam logic [34:0] SEG_RST   = 35'h0;

endpackage

// File: hw/sld_stream_if.sv
// Valid/ready word stream between the design's own modules
`timescale 1ns/1ps
interface sld_stream_if #(
  parameter int WIDTH = 35
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// File: hw/sld_top.sv
// Serial two-wire display latch: link-side shift chain, crossing, FIFO, output latches
`timescale 1ns/1ps
module sld_top #(
  parameter int       NOUT       = sld_pkg::DATA_BITS,
  parameter bit       HAS_ENABLE = 1'b0,
  parameter int       DEPTH      = sld_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic            mclk,
  input  wire logic            sys_rst,
  // Serial link from the host
  input  wire logic            sclk,
  input  wire logic            sdata,
  input  wire logic            en_n,
  // Display control
  input  wire logic            hold_display,
  // Segment outputs, bit 0 is output 1
  output logic [NOUT-1:0]      seg_on
);

  // ==========================================================
  // Link-domain state (runs on sclk)
  typedef struct packed {
    logic                      rst_s1;
    logic                      rst_s2;
    logic                      ack_s1;
    logic                      ack_s2;
    logic [sld_pkg::CNT_W-1:0] cnt;
    logic [NOUT-1:0]           chain;
    logic [NOUT-1:0]           word;
    logic                      req;
  } sld_link_state_type;

  // ==========================================================
  // Core-domain state (runs on mclk)
  typedef struct packed {
    logic            req_s1;
    logic            req_s2;
    logic            seen;
    logic            ack;
    logic            hold_s1;
    logic            hold_s2;
    logic [NOUT-1:0] seg;
  } sld_core_state_type;

  sld_link_state_type ls;
  sld_link_state_type next_ls;
  sld_core_state_type cs;
  sld_core_state_type next_cs;

  logic link_rst;
  logic link_en;
  logic link_busy;
  logic last_bit;
  logic new_req;
  logic pop;

  sld_stream_if #(.WIDTH(NOUT)) push_if ();
  sld_stream_if #(.WIDTH(NOUT)) pop_if ();

  // ==========================================================
  // Link side: shift chain and frame counter
  assign link_rst  = ls.rst_s2;
  assign link_en   = !HAS_ENABLE || !en_n;
  assign link_busy = ls.req != ls.ack_s2;
  assign last_bit  = ls.cnt == sld_pkg::CNT_LAST;

  always_comb begin
    next_ls        = ls;
    // Reset and acknowledge both cross into the stopped-clock domain by two flops
    next_ls.rst_s1 = sys_rst;
    next_ls.rst_s2 = ls.rst_s1;
    next_ls.ack_s1 = cs.ack;
    next_ls.ack_s2 = ls.ack_s1;
    if (link_rst) begin
      next_ls.cnt   = sld_pkg::CNT_IDLE;                                // [RL8]
      next_ls.chain = '0;                                               // [RL8]
      next_ls.word  = '0;
      next_ls.req   = 1'b0;
    end else if (link_en) begin                                         // [RL16]
      if (ls.cnt == sld_pkg::CNT_IDLE) begin
        // Only a one on the data line opens a frame
        if (sdata) begin
          next_ls.cnt = sld_pkg::CNT_FIRST;                             // [RL9]
        end
      end else begin
        next_ls.chain[ls.cnt - 1'b1] = sdata;                           // [RL10] [RL1]
        next_ls.cnt                  = ls.cnt + 1'b1;
        if (last_bit) begin
          // Transfer and clear in one edge; the next rising edge is free for a start bit
          if (!link_busy) begin
            next_ls.word              = ls.chain;                       // [RL3] [RL4]
            next_ls.word[NOUT-1]      = sdata;                          // [RL3]
            next_ls.req               = !ls.req;
          end
          next_ls.chain = '0;                                           // [RL5]
          next_ls.cnt   = sld_pkg::CNT_IDLE;                            // [RL6] [RL7]
        end
      end
    end
  end

  // Data is sampled on the rising serial edge
  always_ff @(posedge sclk) begin                                       // [RL15]
    ls <= next_ls;
  end

  // ==========================================================
  // Core side: request crossing, FIFO push and latch update
  assign new_req        = cs.req_s2 != cs.seen;
  assign push_if.valid  = new_req;
  // Word is stable until the acknowledge toggles back, so no synchroniser is needed on it
  assign push_if.data   = ls.word;
  assign pop_if.ready   = !cs.hold_s2;
  assign pop            = pop_if.valid && pop_if.ready;

  always_comb begin
    next_cs         = cs;
    next_cs.req_s1  = ls.req;
    next_cs.req_s2  = cs.req_s1;
    next_cs.hold_s1 = hold_display;
    next_cs.hold_s2 = cs.hold_s1;
    if (new_req && push_if.ready) begin
      next_cs.seen = cs.req_s2;
      next_cs.ack  = cs.req_s2;
    end
    if (pop) begin
      next_cs.seg = pop_if.data;                                        // [RL11] [RL12]
      if (HAS_ENABLE) begin
        next_cs.seg[NOUT-1] = 1'b0;                                     // [RL13]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cs      <= '0;
      cs.seg  <= sld_pkg::SEG_RST[NOUT-1:0];                            // [RL8]
    end else begin
      cs <= next_cs;
    end
  end

  assign seg_on = cs.seg;

  // ==========================================================
  // Frame buffer between the crossing and the latches
  // A full FIFO stalls the acknowledge, which makes the link drop later frames
  sld_fifo #(
    .WIDTH (NOUT),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk (mclk),
    .rst (sys_rst),
    .wr  (push_if),
    .rd  (pop_if)
  );

  // ==========================================================
  // Link-domain checks
  a_start_arms: assert property (@(posedge sclk) disable iff (link_rst) // [RL9]
    (ls.cnt == sld_pkg::CNT_IDLE && link_en && sdata) |=> ls.cnt == sld_pkg::CNT_FIRST)
    else $error("start bit did not open a frame");

  a_idle_stays: assert property (@(posedge sclk) disable iff (link_rst) // [RL2]
    (ls.cnt == sld_pkg::CNT_IDLE && link_en && !sdata) |=> ls.cnt == sld_pkg::CNT_IDLE)
    else $error("zero opened a frame");

  a_first_bit_out1: assert property (@(posedge sclk) disable iff (link_rst) // [RL10]
    (ls.cnt == sld_pkg::CNT_FIRST && link_en) |=> ls.chain[0] == $past(sdata))
    else $error("first data bit not in stage one");

  a_load_clears: assert property (@(posedge sclk) disable iff (link_rst) // [RL5]
    (last_bit && link_en) |=> ls.cnt == sld_pkg::CNT_IDLE && ls.chain == '0)
    else $error("chain not cleared after last bit");

  a_load_word: assert property (@(posedge sclk) disable iff (link_rst) // [RL3]
    (last_bit && link_en && !link_busy)
      |=> ls.word == {$past(sdata), $past(ls.chain[NOUT-2:0])} && ls.req != $past(ls.req))
    else $error("latched word differs from shifted frame");

  a_only_last_loads: assert property (@(posedge sclk) disable iff (link_rst) // [RL4]
    !(last_bit && link_en) |=> ls.req == $past(ls.req))
    else $error("transfer before the last bit");

  a_disabled_frozen: assert property (@(posedge sclk) disable iff (link_rst) // [RL16]
    !link_en |=> ls.cnt == $past(ls.cnt) && ls.chain == $past(ls.chain))
    else $error("chain moved while disabled");

  // ==========================================================
  // Core-domain checks
  a_seg_static: assert property (@(posedge mclk) disable iff (sys_rst) // [RL12]
    !pop |=> $stable(seg_on))
    else $error("outputs changed without a new frame");

  a_seg_follows: assert property (@(posedge mclk) disable iff (sys_rst) // [RL11]
    (pop && !HAS_ENABLE) |=> seg_on == $past(pop_if.data))
    else $error("outputs differ from latched frame");

  a_enable_pin_slot: assert property (@(posedge mclk) disable iff (sys_rst) // [RL13]
    HAS_ENABLE |-> seg_on[NOUT-1] == 1'b0)
    else $error("last output driven on enable variant");

  a_reset_clears: assert property (@(posedge mclk) // [RL8]
    sys_rst |=> seg_on == '0)
    else $error("outputs not cleared by reset");

  a_push_acks: assert property (@(posedge mclk) disable iff (sys_rst) // [RL3]
    (new_req && push_if.ready) |=> !new_req && cs.ack != $past(cs.ack))
    else $error("accepted frame not acknowledged");

  c_frame_loaded:  cover property (@(posedge sclk) disable iff (link_rst)
    last_bit && link_en && !link_busy);
  c_back_to_back:  cover property (@(posedge sclk) disable iff (link_rst)
    (last_bit && link_en) ##1 (link_en && sdata));
  c_latch_update:  cover property (@(posedge mclk) disable iff (sys_rst) pop);
  c_held_display:  cover property (@(posedge mclk) disable iff (sys_rst)
    pop_if.valid && !pop_if.ready);

endmodule // sld_top

// File: tb/sld_host.sv
// Host model that clocks frames into the two-wire serial link
`timescale 1ns/1ps
module sld_host (
  // Link pins
  output logic sclk,
  output logic sdata,
  output logic en_n
);
  // ==========================================================
  // Link timing
  // 32 ns period: far above the hardware ceiling, kept short for run time
  localparam time HALF = 16ns;

  initial begin
    sclk  = 1'b1;
    sdata = 1'b0;
    en_n  = 1'b0;
  end

  // ==========================================================
  // Bit sender: v[0] is the start bit, v[k] is data bit k
  task automatic bits(input logic [35:0] v, input int from, input int to);
    for (int i = from; i <= to; i++) begin
      #(HALF) sclk = 1'b0;
      sdata = v[i];
      #(HALF) sclk = 1'b1;
    end
    // Data no longer held once the rising edge has passed
    // An odd tail keeps the link edges off the system clock edges
    #4.3ns sdata = ~sdata;
  endtask

  // Changed only between frames, while the serial clock stands high
  task automatic set_en_n(input logic v);
    en_n = v;
  endtask

  task automatic frame(input logic [34:0] w);
    bits({w, 1'b1}, 0, 35);
  endtask

  task automatic idle(input int n);
    bits(36'h0, 0, n - 1);
  endtask
endmodule // sld_host

// File: tb/tb.sv
// Self-checking bench for the serial display latch
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %0t %s", $time, msg); end end
module tb;
  logic        mclk;
  logic        sys_rst;
  logic        hold_display;
  logic        sclk;
  logic        sdata;
  logic        en_n;
  logic [34:0] seg_on;
  logic [34:0] seg_en_on;
  int          fail_count = 0;
  int          n_checks   = 0;

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  sld_host sld_host_i (.sclk(sclk), .sdata(sdata), .en_n(en_n));

  sld_top sld_top_i (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .sclk        (sclk),
    .sdata       (sdata),
    .en_n        (en_n),
    .hold_display(hold_display),
    .seg_on      (seg_on)
  );

  // Enable variant on the same link: its top output gives way to the enable pin
  sld_top #(
    .HAS_ENABLE(1'b1)
  ) sld_top_en_i (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .sclk        (sclk),
    .sdata       (sdata),
    .en_n        (en_n),
    .hold_display(hold_display),
    .seg_on      (seg_en_on)
  );

  // Ends on a falling edge so that outputs are read once settled
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // ==========================================================
  // Scenarios
  // One frame; output must stand for 2 cycles and land by the 8th
  task automatic send_chk(input logic [34:0] w, input bit en_live);
    logic [34:0] old;
    logic [34:0] old_en;
    logic [34:0] exp_en;
    old    = seg_on;
    old_en = seg_en_on;
    exp_en = en_live ? {1'b0, w[33:0]} : old_en;
    sld_host_i.frame(w);
    cyc(2);
    `CHK(seg_on, old, "latched too early")
    `CHK(seg_en_on, old_en, "enable variant latched too early")
    cyc(6);
    `CHK(seg_on, w, "frame not latched")
    `CHK(seg_en_on, exp_en, "enable variant frame")
  endtask

  task automatic t_order;
    logic [34:0] pats [3] = '{35'h1, 35'h4_0000_0000, 35'h5_5555_5555};
    foreach (pats[i]) send_chk(pats[i], 1'b1);
    $display("test order done");
  endtask

  task automatic t_enable;
    sld_host_i.set_en_n(1'b1);
    send_chk(35'h6_1111_2222, 1'b0);
    sld_host_i.set_en_n(1'b0);
    send_chk(35'h4_0f0f_0001, 1'b1);
    $display("test input enable done");
  endtask

  task automatic t_b2b;
    sld_host_i.frame(35'h2_aaaa_0f0f);
    sld_host_i.frame(35'h7_0000_ffff);
    cyc(2);
    `CHK(seg_on, 35'h2_aaaa_0f0f, "first of pair")
    `CHK(seg_en_on, 35'h2_aaaa_0f0f, "first of pair, enable variant")
    cyc(6);
    `CHK(seg_on, 35'h7_0000_ffff, "second of pair")
    `CHK(seg_en_on, 35'h3_0000_ffff, "second of pair, enable variant")
    $display("test back to back done");
  endtask

  task automatic t_short;
    logic [35:0] v;
    v = {35'h3_1234_5678, 1'b1};
    sld_host_i.idle(3);
    sld_host_i.bits(v, 0, 19);
    cyc(12);
    `CHK(seg_on, 35'h7_0000_ffff, "short burst latched")
    `CHK(seg_en_on, 35'h3_0000_ffff, "short burst latched, enable variant")
    sld_host_i.bits(v, 20, 35);
    cyc(8);
    `CHK(seg_on, 35'h3_1234_5678, "completed burst")
    `CHK(seg_en_on, 35'h3_1234_5678, "completed burst, enable variant")
    $display("test short burst done");
  endtask

  task automatic t_hold;
    int          changes;
    int          changes_en;
    logic [34:0] prev;
    logic [34:0] prev_en;
    @(posedge mclk);
    hold_display <= 1'b1;
    cyc(3);
    for (int i = 0; i < 11; i++) sld_host_i.frame(35'h100 + 35'(i));
    cyc(8);
    `CHK(seg_on, 35'h3_1234_5678, "changed while held")
    `CHK(seg_en_on, 35'h3_1234_5678, "enable variant changed while held")
    prev       = seg_on;
    prev_en    = seg_en_on;
    changes    = 0;
    changes_en = 0;
    @(posedge mclk);
    hold_display <= 1'b0;
    for (int i = 0; i < 200; i++) begin
      @(negedge mclk);
      if (seg_on !== prev) changes++;
      if (seg_en_on !== prev_en) changes_en++;
      prev    = seg_on;
      prev_en = seg_en_on;
    end
    // Eight FIFO words, the head word and the word parked in the crossing survive;
    // the eleventh frame meets a busy crossing and is dropped
    `CHK(changes, 10, "buffered frame count")
    `CHK(changes_en, 10, "buffered frame count, enable variant")
    `CHK(seg_on, 35'h109, "last buffered frame")
    `CHK(seg_en_on, 35'h109, "last buffered frame, enable variant")
    $display("test hold and drain done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst      = 1'b1;
    hold_display = 1'b0;
    // Reset stretched so the link side sees enough link edges
    fork
      sld_host_i.idle(4);
      cyc(16);
    join
    `CHK(seg_on, 35'h0, "reset value")
    `CHK(seg_en_on, 35'h0, "enable variant reset value")
    @(posedge mclk);
    sys_rst <= 1'b0;
    sld_host_i.idle(2);
    t_order;
    t_enable;
    t_b2b;
    t_short;
    t_hold;
    end_of_test;
  end
endmodule // tb
